// *** design/voltage_comparator_control.sv ***
// Control and status logic around the on-chip voltage comparator
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"

module voltage_comparator_control (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // Analog core: sign of positive minus negative, and the difference
  input wire logic analog_diff_pos_in,
  input wire logic [7:0] analog_diff_mv_in,
  output comparator_pkg::analog_ctrl_t analog_ctrl_out,
  // Interrupt handler
  input wire logic source_irq_enable_in,
  input wire logic global_irq_enable_in,
  output logic irq_out,
  // Outputs to wake-up, reset logic and port routing
  output logic raw_compare_output_out,
  output logic latched_compare_output_out
);

  // How a change on the analog side travels through this block:
  //   cycle 0   the core inputs move and the raw output follows at once,
  //             with no clock involved, so wake-up logic can use it asleep
  //   edge 1    the hysteresis memory takes the new decision
  //   edge 1-2  the two synchroniser stages take the raw level
  //   edge 3    the sampled level moves, the edge flag sets and the
  //             latched output changes
  // Software therefore sees a change three clocks after the raw pin, and
  // a pulse on the raw output shorter than a clock may set no flag.
  // The hysteresis memory only advances while the clock runs; with the
  // clock stopped the raw output still follows the inputs, but against
  // the last held decision. Holding the clock enable low freezes every
  // register here, flags included, so no edge is flagged while frozen.
  // A write that enables the comparator, or that moves the hysteresis or
  // the response mode, may let the analog core throw a false edge;
  // software is expected to clear both flags a little later.

  // Every register comes out of reset cleared except the response mode,
  // which starts in its middle setting; the comparator itself starts
  // disabled, so the outputs are low and no edge can set a flag until software
  // turns it on.

  // Control register state
  logic comparator_on_bit;
  logic rising_edge_flag;
  logic falling_edge_flag;
  logic [1:0] positive_hysteresis_select;
  logic [1:0] negative_hysteresis_select;
  // Mode register state
  logic rising_edge_irq_enable;
  logic falling_edge_irq_enable;
  comparator_pkg::response_mode_t response_mode_field;
  // Comparator core state
  logic raw_state;
  logic next_raw;
  logic latched_level;
  comparator_pkg::edge_event_t edges;
  logic [7:0] hyp_mv;
  logic [7:0] hyn_mv;
  logic ctrl_wr;
  logic mode_wr;
  logic ctrl_rd;
  logic mode_rd;
  // Per-direction views, index 1 rising and index 0 falling
  logic edge_vec [2];
  logic flag_wr_bit [2];
  logic flag_vec [2];
  // Reset image of the mode register, sliced for the response field
  localparam logic [7:0] MODE_RESET_VAL = `MODE_RESET;

  // Hysteresis coding, the same for the positive and negative fields:
  //   code 0   no hysteresis, the threshold is the negative input
  //   code 1   smallest step
  //   code 2   middle step
  //   code 3   largest step
  // The core model works on a difference in millivolts, so each code is
  // turned into that amount once here and compared directly; a real
  // analog core would take the select codes from the settings port
  // instead.

  // Decode a two-bit hysteresis code into millivolts
  function automatic logic [7:0] hyst_mv(input logic [1:0] code);
    unique case (code)
      2'h0: hyst_mv = `HYST_CODE0_MV;
      2'h1: hyst_mv = `HYST_CODE1_MV;
      2'h2: hyst_mv = `HYST_CODE2_MV;
      2'h3: hyst_mv = `HYST_CODE3_MV;
    endcase
  endfunction

  // Address decode shared by the write and read paths
  function automatic logic addr_is(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_is = (addr == target);
  endfunction

  // Hysteresis decision for one sample of the analog difference; held is
  // the previous decision, which is what makes the thresholds asymmetric
  function automatic logic decide(
    input logic held,
    input logic diff_pos,
    input logic [7:0] diff_mv,
    input logic [7:0] up_mv,
    input logic [7:0] down_mv
  );
    decide = held;
    if (diff_pos) begin
      // Rise only once above threshold by the positive amount
      if (diff_mv > up_mv) begin
        decide = 1'b1;
      end else if (up_mv == 8'h00 && diff_mv != 8'h00) begin
        decide = 1'b1;
      end
    end else begin
      // Fall only once below threshold by the negative amount
      if (diff_mv > down_mv) begin
        decide = 1'b0;
      end else if (down_mv == 8'h00) begin
        decide = 1'b0;
      end
    end
  endfunction

  assign hyp_mv = hyst_mv(positive_hysteresis_select);
  assign hyn_mv = hyst_mv(negative_hysteresis_select);

  // Writes are taken only on an enabled clock
  assign ctrl_wr = clk_en_in & sfr_wr_in & addr_is(sfr_addr_in, `CTRL_ADDR);
  assign mode_wr = clk_en_in & sfr_wr_in & addr_is(sfr_addr_in, `MODE_ADDR);

  // Comparator decision with hysteresis; the state bit models the
  // analog core's memory; the decision is combinational from its inputs
  always_comb begin
    if (!comparator_on_bit) begin
      next_raw = 1'b0;
    end else begin
      next_raw = decide(raw_state, analog_diff_pos_in, analog_diff_mv_in,
        hyp_mv, hyn_mv);
    end
  end

  // Held decision; sampled only to keep hysteresis memory in this model,
  // the raw output itself is combinational and needs no clock
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      raw_state <= 1'b0;
    end else if (clk_en_in) begin
      raw_state <= next_raw;
    end
  end

  // Raw output follows the core directly, valid with the clock stopped
  assign raw_compare_output_out = next_raw & comparator_on_bit;

  // Synchronise the raw output and find its edges
  edge_detect sync_edges (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .async_in(raw_compare_output_out),
    .level_out(latched_level),
    .edge_out(edges)
  );

  // Latched output is forced low the moment the comparator is off
  assign latched_compare_output_out = latched_level & comparator_on_bit;

  // Enable bit and hysteresis selects
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      comparator_on_bit <= 1'b0;
      positive_hysteresis_select <= 2'h0;
      negative_hysteresis_select <= 2'h0;
    end else if (ctrl_wr) begin
      comparator_on_bit <= sfr_wdata_in[`CTRL_ON_BIT];
      positive_hysteresis_select <=
        sfr_wdata_in[`CTRL_HYP_HI:`CTRL_HYP_LO];
      negative_hysteresis_select <=
        sfr_wdata_in[`CTRL_HYN_HI:`CTRL_HYN_LO];
    end
  end

  // Direction views of events and write data, so both flags share one
  // description below and cannot drift apart
  assign edge_vec[1] = edges.rise;
  assign edge_vec[0] = edges.fall;
  assign flag_wr_bit[1] = sfr_wdata_in[`CTRL_RISE_FLAG_BIT];
  assign flag_wr_bit[0] = sfr_wdata_in[`CTRL_FALL_FLAG_BIT];

  // Sticky edge flags; a new edge wins over a software clear, so an edge
  // that lands in the very cycle of the clear is never lost
  for (genvar g = 0; g < 2; g++) begin : g_flag
    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        flag_vec[g] <= 1'b0;
      end else if (clk_en_in) begin
        if (edge_vec[g]) begin
          flag_vec[g] <= 1'b1;
        end else if (ctrl_wr) begin
          flag_vec[g] <= flag_wr_bit[g];
        end
      end
    end
  end

  // Named views for the read path and the interrupt gate
  assign rising_edge_flag = flag_vec[1];
  assign falling_edge_flag = flag_vec[0];

  // Mode register: interrupt enables and response mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rising_edge_irq_enable <= 1'b0;
      falling_edge_irq_enable <= 1'b0;
      response_mode_field <= comparator_pkg::response_mode_t'(
        MODE_RESET_VAL[`MODE_MD_HI:`MODE_MD_LO]);
    end else if (mode_wr) begin
      rising_edge_irq_enable <= sfr_wdata_in[`MODE_RISE_IE_BIT];
      falling_edge_irq_enable <= sfr_wdata_in[`MODE_FALL_IE_BIT];
      response_mode_field <= comparator_pkg::response_mode_t'(
        sfr_wdata_in[`MODE_MD_HI:`MODE_MD_LO]);
    end
  end

  // Settings to the analog core; shutdown overrides any mode
  always_comb begin
    analog_ctrl_out.comparator_on = comparator_on_bit;
    analog_ctrl_out.shutdown = ~comparator_on_bit;
    analog_ctrl_out.response_mode = response_mode_field;
    analog_ctrl_out.positive_hysteresis_select = positive_hysteresis_select;
    analog_ctrl_out.negative_hysteresis_select = negative_hysteresis_select;
  end

  // Interrupt request is gated by every enable on the way
  assign irq_out = source_irq_enable_in & global_irq_enable_in &
    ((rising_edge_flag & rising_edge_irq_enable) |
     (falling_edge_flag & falling_edge_irq_enable));

  // Control image; every bit of this register has a meaning
  function automatic logic [7:0] ctrl_image(
    input logic on,
    input logic result,
    input logic rise,
    input logic fall,
    input logic [1:0] hyp,
    input logic [1:0] hyn
  );
    ctrl_image = `CTRL_RESET;
    ctrl_image[`CTRL_ON_BIT] = on;
    ctrl_image[`CTRL_RESULT_BIT] = result;
    ctrl_image[`CTRL_RISE_FLAG_BIT] = rise;
    ctrl_image[`CTRL_FALL_FLAG_BIT] = fall;
    ctrl_image[`CTRL_HYP_HI:`CTRL_HYP_LO] = hyp;
    ctrl_image[`CTRL_HYN_HI:`CTRL_HYN_LO] = hyn;
  endfunction

  // Mode image; unused bits read 0 and the reserved top bit reads 1
  function automatic logic [7:0] mode_image(
    input logic rise_ie,
    input logic fall_ie,
    input comparator_pkg::response_mode_t mode
  );
    mode_image = 8'h00;
    mode_image[`MODE_RSVD_BIT] = 1'b1;
    mode_image[`MODE_RISE_IE_BIT] = rise_ie;
    mode_image[`MODE_FALL_IE_BIT] = fall_ie;
    mode_image[`MODE_MD_HI:`MODE_MD_LO] = mode;
  endfunction

  // Read data is combinational and stands while the strobe and address
  // are held; an unmapped address answers 0 with no hit
  assign ctrl_rd = sfr_rd_in & addr_is(sfr_addr_in, `CTRL_ADDR);
  assign mode_rd = sfr_rd_in & addr_is(sfr_addr_in, `MODE_ADDR);
  always_comb begin
    sfr_rdata_out = 8'h00;
    sfr_hit_out = ctrl_rd | mode_rd;
    if (ctrl_rd) begin
      sfr_rdata_out = ctrl_image(comparator_on_bit,
        latched_compare_output_out, rising_edge_flag, falling_edge_flag,
        positive_hysteresis_select, negative_hysteresis_select);
    end else if (mode_rd) begin
      sfr_rdata_out = mode_image(rising_edge_irq_enable,
        falling_edge_irq_enable, response_mode_field);
    end
  end

endmodule // voltage_comparator_control

`default_nettype wire

// *** pkg/comparator_cfg.svh ***
// Offsets, field positions, reset values and codes of the comparator control
`ifndef COMPARATOR_CFG_SVH
`define COMPARATOR_CFG_SVH

// Register addresses on the special function register port
`define CTRL_ADDR 8'h9B
`define MODE_ADDR 8'h9D

// Control register fields
`define CTRL_ON_BIT 7
`define CTRL_RESULT_BIT 6
`define CTRL_RISE_FLAG_BIT 5
`define CTRL_FALL_FLAG_BIT 4
`define CTRL_HYP_HI 3
`define CTRL_HYP_LO 2
`define CTRL_HYN_HI 1
`define CTRL_HYN_LO 0
`define CTRL_RESET 8'h00

// Mode register fields
`define MODE_RSVD_BIT 7
`define MODE_RISE_IE_BIT 5
`define MODE_FALL_IE_BIT 4
`define MODE_MD_HI 1
`define MODE_MD_LO 0
`define MODE_RESET 8'h82

// Hysteresis amounts in millivolts, by select code
`define HYST_CODE0_MV 8'h00
`define HYST_CODE1_MV 8'h05
`define HYST_CODE2_MV 8'h0A
`define HYST_CODE3_MV 8'h14

`endif

// *** pkg/comparator_pkg.sv ***
// Types shared by the comparator control files
package comparator_pkg;

  typedef enum logic [1:0] {
    MODE_FAST = 2'h0,
    MODE_1 = 2'h1,
    MODE_2 = 2'h2,
    MODE_SLOW = 2'h3
  } response_mode_t;

  // Settings handed to the analog core
  typedef struct packed {
    logic comparator_on;
    logic shutdown;
    response_mode_t response_mode;
    logic [1:0] positive_hysteresis_select;
    logic [1:0] negative_hysteresis_select;
  } analog_ctrl_t;

  // Edge events of one clock cycle
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_event_t;

endpackage

// *** design/edge_detect.sv ***
// Two-stage synchroniser and edge detector for the comparator result
`timescale 1ns/1ps
`default_nettype none

module edge_detect (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Asynchronous level
  input wire logic async_in,
  // Synchronised level and events
  output logic level_out,
  output comparator_pkg::edge_event_t edge_out
);

  logic meta;
  logic sync;
  logic prev;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else if (clk_en_in) begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_out = prev;
  // One event per direction per cycle at most
  assign edge_out.rise = clk_en_in & sync & ~prev;
  assign edge_out.fall = clk_en_in & ~sync & prev;

endmodule // edge_detect

`default_nettype wire

// *** test/analog_source_model.sv ***
// Analog input pair seen as the sign and size of the difference
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
  // Input levels in millivolts
  input wire logic [7:0] pos_mv_in,
  input wire logic [7:0] neg_mv_in,
  // Difference as the comparator core sees it
  output logic diff_pos_out,
  output logic [7:0] diff_mv_out
);
  // Equal levels count as not above, so no test may lean on a tie
  assign diff_pos_out = pos_mv_in > neg_mv_in;
  assign diff_mv_out = diff_pos_out ? pos_mv_in - neg_mv_in
    : neg_mv_in - pos_mv_in;
endmodule // analog_source_model
`default_nettype wire

// *** test/vcc_properties.sv ***
// Port-level checks for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"
module vcc_properties (
  // Clock, reset and register writes
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  // Analog core, interrupt gating and outputs
  input wire logic analog_diff_pos_in,
  input wire logic [7:0] analog_diff_mv_in,
  input wire comparator_pkg::analog_ctrl_t analog_ctrl_out,
  input wire logic source_irq_enable_in,
  input wire logic global_irq_enable_in,
  input wire logic irq_out,
  input wire logic raw_compare_output_out,
  input wire logic latched_compare_output_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // A write may move the settings, so write cycles are left out
  wire logic on_w = analog_ctrl_out.comparator_on;
  wire logic raw_w = raw_compare_output_out;
  wire logic lat_w = latched_compare_output_out;
  wire logic up_w = analog_diff_pos_in;
  wire logic calm_w = on_w && clk_en_in && !sfr_wr_in;
  wire logic [3:0] hyst_w = analog_ctrl_out[3:0];
  wire logic wr_w = sfr_wr_in && clk_en_in;
  AST_OFF_ZERO: assert property (!on_w |-> !raw_w && !lat_w)
    else $error("output high while comparator off");
  AST_NO_HYST: assert property (calm_w && hyst_w == 4'h0 && up_w
      && analog_diff_mv_in != 8'h00 |-> raw_w)
    else $error("result not high above threshold");
  AST_POS_HYST: assert property (clk_en_in && !raw_w ##1 calm_w
      && hyst_w[3:2] == 2'h3 && up_w && analog_diff_mv_in < 8'h14 |-> !raw_w)
    else $error("rose inside positive hysteresis");
  AST_NEG_HYST: assert property (clk_en_in && raw_w ##1 calm_w
      && hyst_w[1:0] == 2'h3 && !up_w && analog_diff_mv_in < 8'h14 |-> raw_w)
    else $error("fell inside negative hysteresis");
  AST_SYNC_HIGH: assert property ((clk_en_in && raw_w)[*4] |-> lat_w)
    else $error("latched output missed a steady high");
  AST_SYNC_LOW: assert property ((clk_en_in && !raw_w)[*4] |-> !lat_w)
    else $error("latched output missed a steady low");
  AST_IRQ_GATE: assert property (!(source_irq_enable_in
      && global_irq_enable_in) |-> !irq_out)
    else $error("request without source and global enable");
  AST_MODE_WR: assert property (wr_w && sfr_addr_in == `MODE_ADDR |=>
      {6'h00, analog_ctrl_out.response_mode} == ($past(sfr_wdata_in) & 8'h03))
    else $error("response mode not taken from write");
  AST_CTRL_WR: assert property (wr_w && sfr_addr_in == `CTRL_ADDR |=>
      {on_w, 3'h0, hyst_w} == ($past(sfr_wdata_in) & 8'h8F))
    else $error("control write not applied");
  cover property ($rose(irq_out));
  cover property ($rose(lat_w));
  cover property ($fell(lat_w));
endmodule // vcc_properties

bind voltage_comparator_control vcc_properties u_props (.mclk_in(mclk_in),
  .reset_in(reset_in), .clk_en_in(clk_en_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
  .analog_diff_pos_in(analog_diff_pos_in), .irq_out(irq_out),
  .analog_diff_mv_in(analog_diff_mv_in), .analog_ctrl_out(analog_ctrl_out),
  .source_irq_enable_in(source_irq_enable_in),
  .global_irq_enable_in(global_irq_enable_in),
  .raw_compare_output_out(raw_compare_output_out),
  .latched_compare_output_out(latched_compare_output_out));
`default_nettype wire

// *** test/test_voltage_comparator_control.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "comparator_cfg.svh"
module test_voltage_comparator_control;
  logic mclk_in = 1'b0, reset_in = 1'b1, wr = 1'b0, rd = 1'b0, src = 1'b0;
  logic glb = 1'b0, exp_irq = 1'b0, up, irq, hit;
  logic [7:0] addr = 8'h00, wdata = 8'h00, pos = 8'h32, mv, rdata, m;
  logic [7:0] amt [4] = '{`HYST_CODE0_MV, `HYST_CODE1_MV, `HYST_CODE2_MV,
    `HYST_CODE3_MV};
  logic [9:0] exp_q [$];
  int bad_count = 0, n_checks = 0, cycles = 0;
  // Free-running 10 MHz clock
  always #50 mclk_in = ~mclk_in;
  analog_source_model u_src (.pos_mv_in(pos), .neg_mv_in(8'h64),
    .diff_pos_out(up), .diff_mv_out(mv));
  voltage_comparator_control u_dut (.mclk_in(mclk_in), .reset_in(reset_in),
    .clk_en_in(1'b1), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .analog_diff_pos_in(up), .analog_diff_mv_in(mv), .analog_ctrl_out(),
    .source_irq_enable_in(src), .global_irq_enable_in(glb), .irq_out(irq),
    .raw_compare_output_out(), .latched_compare_output_out());
  // One bus cycle from a falling edge; a read notes the answer it expects
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    addr = a;
    wdata = d;
    {wr, rd} = {w, !w};
    if (!w) exp_q.push_back({exp_irq, a == `CTRL_ADDR || a == `MODE_ADDR, d});
    @(negedge mclk_in);
    {wr, rd} = 2'h0;
  endtask
  task check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task complete_run();
    $display("%0d checks, %0d mismatches", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Scoreboard on each sampled read, plus a cap on run length
  always @(posedge mclk_in) begin
    cycles++;
    if (rd) check({irq, hit, rdata}, exp_q.pop_front());
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  // Far side of the threshold, just short of the hysteresis, then past it
  task hyst(input logic [1:0] c, input logic neg);
    m = neg ? {6'h20, c} : {4'h8, c, 2'h0};
    pos = neg ? 8'h96 : 8'h32;
    bus(1'b1, `CTRL_ADDR, m);
    repeat (6) @(negedge mclk_in);
    pos = neg ? 8'h65 - amt[c] : 8'h63 + amt[c];
    repeat (6) @(negedge mclk_in);
    bus(1'b1, `CTRL_ADDR, m);
    bus(1'b0, `CTRL_ADDR, m | {1'b0, neg, 6'h00});
    pos = neg ? 8'h63 - amt[c] : 8'h65 + amt[c];
    repeat (6) @(negedge mclk_in);
    bus(1'b1, `CTRL_ADDR, m);
    bus(1'b0, `CTRL_ADDR, m | {1'b0, !neg, 6'h00});
  endtask
  initial begin
    void'($urandom(13517));
    repeat (10) @(negedge mclk_in);
    reset_in = 1'b0;
    bus(1'b0, `CTRL_ADDR, `CTRL_RESET);
    bus(1'b0, `MODE_ADDR, `MODE_RESET);
    bus(1'b1, 8'h9C, 8'hFF);
    bus(1'b0, 8'h9C, 8'h00);
    // Enable while high, clear power-up edges, then fall and rise
    pos = 8'h96;
    bus(1'b1, `CTRL_ADDR, 8'h80);
    repeat (6) @(negedge mclk_in);
    bus(1'b1, `CTRL_ADDR, 8'hC0);
    bus(1'b0, `CTRL_ADDR, 8'hC0);
    pos = 8'h32;
    repeat (6) @(negedge mclk_in);
    bus(1'b0, `CTRL_ADDR, 8'h90);
    pos = 8'h96;
    repeat (6) @(negedge mclk_in);
    bus(1'b0, `CTRL_ADDR, 8'hF0);
    // Every enable pair and mode code; random gating and ignored bits
    for (int i = 0; i < 16; i++) begin
      {src, glb} = i < 12 ? 2'h3 : 2'($urandom);
      m = {2'h2, i[3:2], 2'h0, i[1:0]};
      bus(1'b1, `MODE_ADDR, m | {1'b0, 1'($urandom), 2'h0, 2'($urandom),
        2'h0});
      exp_irq = (i[3] | i[2]) & src & glb;
      bus(1'b0, `MODE_ADDR, m);
    end
    {src, glb} = 2'h3;
    exp_irq = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hyst(i[1:0], i[2]);
    end
    // Switching off while high drops the result and flags the fall
    pos = 8'h96;
    bus(1'b1, `CTRL_ADDR, 8'h80);
    repeat (6) @(negedge mclk_in);
    bus(1'b1, `CTRL_ADDR, 8'h80);
    bus(1'b1, `CTRL_ADDR, 8'h00);
    repeat (6) @(negedge mclk_in);
    exp_irq = 1'b1;
    bus(1'b0, `CTRL_ADDR, 8'h10);
    complete_run();
  end
endmodule // test_voltage_comparator_control
`default_nettype wire
